//--- rtl/ebpwm_map.svh
// Offsets, fields, reset values and timing counts of the bridge PWM.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef EBPWM_MAP_SVH
`define EBPWM_MAP_SVH

// Register offsets
`define EBPWM_OFF_CONTROL 3'h0
`define EBPWM_OFF_DUTY_HIGH 3'h1
`define EBPWM_OFF_DUTY_SHADOW 3'h2
`define EBPWM_OFF_PERIOD 3'h3
`define EBPWM_OFF_DEAD_BAND 3'h4
`define EBPWM_OFF_TIMER_CTRL 3'h5
`define EBPWM_OFF_TIMER 3'h6
`define EBPWM_OFF_STATUS 3'h7

// Control register fields
`define EBPWM_CFG_HI 7
`define EBPWM_CFG_LO 6
`define EBPWM_DLB_HI 5
`define EBPWM_DLB_LO 4
`define EBPWM_MODE_HI 3
`define EBPWM_MODE_LO 0
`define EBPWM_MODE_PWM 2'h3
`define EBPWM_CFG_SINGLE 2'h0
`define EBPWM_CFG_FORWARD 2'h1
`define EBPWM_CFG_HALF 2'h2
`define EBPWM_CFG_REVERSE 2'h3

// Dead-band and timer control fields
`define EBPWM_DB_HI 6
`define EBPWM_TCTL_PRE_HI 1
`define EBPWM_TCTL_ON 2
`define EBPWM_TCTL_POST_HI 6
`define EBPWM_TCTL_POST_LO 3
`define EBPWM_PRE_1 2'h0
`define EBPWM_PRE_4 2'h1

// Reset values
`define EBPWM_RST_CONTROL 8'h00
`define EBPWM_RST_BYTE 8'h00
`define EBPWM_RST_PERIOD 8'hFF
`define EBPWM_RST_DEAD_BAND 7'h00
`define EBPWM_RST_TCTL 7'h00

// Timing: the system clock is the oscillator, an instruction cycle is 4 of them
`define EBPWM_CLK_NS 10
`define EBPWM_TOSC_NS 10
`define EBPWM_TOSC_PER_INSTR 4
`define EBPWM_INSTR_CLKS ((`EBPWM_TOSC_PER_INSTR * `EBPWM_TOSC_NS) / `EBPWM_CLK_NS)

`endif

//--- rtl/ebpwm_pkg.sv
// Types shared by the bridge PWM modules.
// Assumes nothing beyond the constants header.
package ebpwm_pkg;

    typedef enum logic [1:0]
    {
        EBPWM_IDLE,
        EBPWM_ARMED,
        EBPWM_RUN
    } ebpwm_state_t;

endpackage

//--- rtl/ebpwm_timebase.sv
// Period timer with 1/4/16 prescaler and period compare.
// Assumes clk_sys is the oscillator clock.
`timescale 1ns/1ns
`include "ebpwm_map.svh"

module ebpwm_timebase
    import ebpwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Control
    input wire logic run,
    input wire logic [1:0] pre_sel,
    input wire logic [7:0] period,
    // Time base
    output logic [7:0] period_timer,
    output logic [1:0] fine_bits,
    output logic step,
    output logic boundary
);

    logic [5:0] presc_ff;
    logic [7:0] timer_ff;

    // Step once every 4, 16 or 64 oscillator periods
    always_comb
    begin
        if (pre_sel == `EBPWM_PRE_1)
        begin
            step = run && (presc_ff[1:0] == 2'h3);
            fine_bits = presc_ff[1:0];
        end
        else if (pre_sel == `EBPWM_PRE_4)
        begin
            step = run && (presc_ff[3:0] == 4'hF);
            fine_bits = presc_ff[3:2];
        end
        else
        begin
            step = run && (presc_ff == 6'h3F);
            fine_bits = presc_ff[5:4];
        end
    end

    // Clears on the increment after the timer equals the period
    assign boundary = step && (timer_ff == period);
    assign period_timer = timer_ff;

    always_ff @(posedge clk_sys)
    begin
        if (srst || !run)
            presc_ff <= 6'h00;
        else
            presc_ff <= presc_ff + 6'h01;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst || !run)
            timer_ff <= 8'h00;
        else if (boundary)
            timer_ff <= 8'h00;
        else if (step)
            timer_ff <= timer_ff + 8'h01;
    end

endmodule

//--- rtl/ebpwm_deadband.sv
// Rising-edge delay for one half-bridge output.
// Assumes level_in is a registered level; the falling edge passes at once.
`timescale 1ns/1ns
`include "ebpwm_map.svh"

module ebpwm_deadband
    import ebpwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Level and delay in instruction cycles
    input wire logic level_in,
    input wire logic [6:0] delay,
    // Delayed level
    output logic level_out
);

    logic [8:0] cnt_ff;
    logic out_ff;
    logic [8:0] target;

    assign target = 9'(delay * `EBPWM_INSTR_CLKS);
    assign level_out = out_ff;

    // A delay past the duty never completes
    always_ff @(posedge clk_sys)
    begin
        if (srst || !level_in)
        begin
            cnt_ff <= 9'h000;
            out_ff <= 1'b0;
        end
        else if (cnt_ff == target)
            out_ff <= 1'b1;
        else
            cnt_ff <= cnt_ff + 9'h001;
    end

endmodule

//--- rtl/ebpwm_top.sv
// Enhanced bridge PWM: registers, buffering, duty compare and output steering.
// Assumes a single-cycle register port; pin direction and the
// comparator-2 pin function stay with software.
//
// How it works
// - Up to 10-bit duty, up to four outputs
// - 00 single, 10 half, 01 forward, 11 reverse
// - Zero control write forces outputs inactive
// - Pins used: A; A,B; or A to D
// - Period is (period+1) x 4 Tosc x prescale
// - Prescale selectable as 1, 4, 16
// - After period match: clear, set, copy duty
// - Zero duty never drives output active
// - Half-bridge edges wait for dead band
// - Postscaler does not affect period
// - Duty is high byte plus two low bits
// - Shadow byte read-only while PWM runs
// - Active phase ends on fine duty match
// - Active time is duty x Tosc x prescale
// - Control settings take effect at period boundary
// - Dead band loads at duty or period boundary
// - Start waits for first timer reset
// - Duty beyond period leaves outputs unchanged
// - Forward: A active, B C inactive, D modulated
// - Reverse: C active, A D inactive, B modulated
// - Half-bridge: A modulated, B complement
// - Dead band counts instruction cycles, may suppress
// - Direction change adopted one prescaled instruction before next period
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "ebpwm_map.svh"

module ebpwm_top
    import ebpwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Bridge outputs and pin ownership
    output logic bridge_out_a,
    output logic bridge_out_b,
    output logic bridge_out_c,
    output logic bridge_out_d,
    output logic bridge_own_a,
    output logic bridge_own_b,
    output logic bridge_own_c,
    output logic bridge_own_d
);

    // Software-visible registers
    logic [7:0] eccp_control_ff;
    logic [7:0] duty_high_byte_ff;
    logic [7:0] duty_shadow_byte_ff;
    logic [7:0] period_register_ff;
    logic [6:0] dead_band_control_ff;
    logic [6:0] timer_ctrl_ff;
    logic [7:0] rdata_ff;

    // Run state, buffered copies in force for the current period, and output flops
    ebpwm_state_t state_ff;
    logic [1:0] cfg_act_ff;
    logic [1:0] pol_act_ff;
    logic [1:0] low_latch_ff;
    logic [7:0] period_act_ff;
    logic [6:0] db_act_ff;
    logic dir_ff;
    logic early_ff;
    logic mod_ff;
    logic [3:0] out_ff;
    logic [3:0] own_ff;

    // Decodes and time base
    logic wr_control;
    logic clear_all;
    logic live_pwm;
    logic running;
    logic [7:0] period_timer;
    logic [1:0] fine_bits;
    logic step;
    logic boundary;
    logic last_step;
    logic duty_match;
    logic [9:0] duty_next;
    logic duty_zero;
    logic duty_over;
    logic mod_eff;
    logic [1:0] db_level;
    logic [3:0] nxt_act;
    logic [3:0] nxt_own;
    logic [3:0] pol_pin;

    assign wr_control = reg_wr && (reg_addr == `EBPWM_OFF_CONTROL);
    assign clear_all = wr_control && (reg_wdata == `EBPWM_RST_CONTROL);
    assign live_pwm = eccp_control_ff[`EBPWM_MODE_HI:`EBPWM_MODE_HI-1] == `EBPWM_MODE_PWM;
    assign running = state_ff == EBPWM_RUN;

    // Postscaler bits stored only, time base ignores them
    ebpwm_timebase u_timebase
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .run(timer_ctrl_ff[`EBPWM_TCTL_ON]),
        .pre_sel(timer_ctrl_ff[`EBPWM_TCTL_PRE_HI:0]),
        .period(period_act_ff),
        .period_timer(period_timer),
        .fine_bits(fine_bits),
        .step(step),
        .boundary(boundary)
    );

    assign last_step = timer_ctrl_ff[`EBPWM_TCTL_ON] && (period_timer == period_act_ff);

    // Ten-bit duty against timer plus fine bits
    assign duty_match = {duty_shadow_byte_ff, low_latch_ff} == {period_timer, fine_bits};

    // Duty that the next period will use
    assign duty_next = {duty_high_byte_ff,
                        eccp_control_ff[`EBPWM_DLB_HI:`EBPWM_DLB_LO]};
    assign duty_zero = duty_next == 10'h000;
    assign duty_over = duty_next > {period_register_ff, 2'h3};

    // Software registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            eccp_control_ff <= `EBPWM_RST_CONTROL;
        else if (wr_control)
            eccp_control_ff <= reg_wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            duty_high_byte_ff <= `EBPWM_RST_BYTE;
        else if (reg_wr && (reg_addr == `EBPWM_OFF_DUTY_HIGH))
            duty_high_byte_ff <= reg_wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            period_register_ff <= `EBPWM_RST_PERIOD;
        else if (reg_wr && (reg_addr == `EBPWM_OFF_PERIOD))
            period_register_ff <= reg_wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            dead_band_control_ff <= `EBPWM_RST_DEAD_BAND;
        else if (reg_wr && (reg_addr == `EBPWM_OFF_DEAD_BAND))
            dead_band_control_ff <= reg_wdata[`EBPWM_DB_HI:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            timer_ctrl_ff <= `EBPWM_RST_TCTL;
        else if (reg_wr && (reg_addr == `EBPWM_OFF_TIMER_CTRL))
            timer_ctrl_ff <= reg_wdata[`EBPWM_TCTL_POST_HI:0];
    end

    // Shadow byte: loaded at the boundary, read-only while running
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            duty_shadow_byte_ff <= `EBPWM_RST_BYTE;
        else if (boundary && (state_ff != EBPWM_IDLE))
            duty_shadow_byte_ff <= duty_high_byte_ff;
        else if (reg_wr && (reg_addr == `EBPWM_OFF_DUTY_SHADOW) && !running)
            duty_shadow_byte_ff <= reg_wdata;
    end

    // Run state: enabling arms, the first timer reset starts
    always_ff @(posedge clk_sys)
    begin
        if (srst || clear_all)
            state_ff <= EBPWM_IDLE;
        else
        begin
            case (state_ff)
                EBPWM_IDLE:
                    if (live_pwm)
                        state_ff <= EBPWM_ARMED;
                EBPWM_ARMED:
                    if (!live_pwm)
                        state_ff <= EBPWM_IDLE;
                    else if (boundary)
                        state_ff <= EBPWM_RUN;
                EBPWM_RUN:
                    if (boundary && !live_pwm)
                        state_ff <= EBPWM_IDLE;
                default:
                    state_ff <= EBPWM_IDLE;
            endcase
        end
    end

    // Control fields go live only at the period boundary
    always_ff @(posedge clk_sys)
    begin
        if (srst || clear_all)
        begin
            cfg_act_ff <= `EBPWM_CFG_SINGLE;
            pol_act_ff <= 2'h0;
            low_latch_ff <= 2'h0;
        end
        else if (boundary && (state_ff != EBPWM_IDLE))
        begin
            cfg_act_ff <= eccp_control_ff[`EBPWM_CFG_HI:`EBPWM_CFG_LO];
            pol_act_ff <= eccp_control_ff[`EBPWM_MODE_LO+1:`EBPWM_MODE_LO];
            low_latch_ff <= eccp_control_ff[`EBPWM_DLB_HI:`EBPWM_DLB_LO];
        end
    end

    // Period follows software while idle so the first period is right
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            period_act_ff <= `EBPWM_RST_PERIOD;
        else if ((state_ff == EBPWM_IDLE) || boundary)
            period_act_ff <= period_register_ff;
    end

    // Dead band loads at duty match and again at the period boundary
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            db_act_ff <= `EBPWM_RST_DEAD_BAND;
        else if (boundary || (running && duty_match))
            db_act_ff <= dead_band_control_ff;
    end

    // Direction flips one prescaled instruction before the period ends; the
    // modulated output is held inactive meanwhile to avoid crossed legs
    always_ff @(posedge clk_sys)
    begin
        if (srst || clear_all)
        begin
            dir_ff <= 1'b0;
            early_ff <= 1'b0;
        end
        else if (boundary)
            early_ff <= 1'b0;
        else if (running && last_step && cfg_act_ff[`EBPWM_CFG_LO]
                 && eccp_control_ff[`EBPWM_CFG_LO]
                 && (eccp_control_ff[`EBPWM_CFG_HI] != dir_ff))
        begin
            dir_ff <= eccp_control_ff[`EBPWM_CFG_HI];
            early_ff <= 1'b1;
        end
        else if (state_ff != EBPWM_RUN)
            dir_ff <= eccp_control_ff[`EBPWM_CFG_HI];
    end

    // Modulated level: set at the boundary, cleared on the fine duty match
    always_ff @(posedge clk_sys)
    begin
        if (srst || clear_all)
            mod_ff <= 1'b0;
        else if (!live_pwm && (state_ff == EBPWM_IDLE))
            mod_ff <= 1'b0;
        else if (boundary && (state_ff != EBPWM_IDLE))
        begin
            if (duty_over)
                mod_ff <= mod_ff;
            else
                mod_ff <= !duty_zero;
        end
        else if (running && duty_match)
            mod_ff <= 1'b0;
    end

    assign mod_eff = mod_ff && !early_ff && !(running && duty_match);

    // Half-bridge legs, each with its own rising-edge delay
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_leg
            ebpwm_deadband u_db
            (
                .clk_sys(clk_sys),
                .srst(srst),
                .level_in(running && (g == 0 ? mod_eff : !mod_eff)),
                .delay(db_act_ff),
                .level_out(db_level[g])
            );
        end
    endgenerate

    // Steering of the active levels and pin ownership
    always_comb
    begin
        nxt_act = 4'h0;
        nxt_own = 4'h0;
        if (state_ff != EBPWM_IDLE)
        begin
            case (cfg_act_ff)
                `EBPWM_CFG_SINGLE:
                begin
                    nxt_own = 4'h1;
                    nxt_act = {3'h0, running && mod_eff};
                end
                `EBPWM_CFG_HALF:
                begin
                    nxt_own = 4'h3;
                    nxt_act = {2'h0, db_level[1], db_level[0]};
                end
                default:
                begin
                    nxt_own = 4'hF;
                    if (running && !dir_ff)
                        nxt_act = {mod_eff, 2'h0, 1'b1};
                    else if (running)
                        nxt_act = {1'b0, 1'b1, mod_eff, 1'b0};
                end
            endcase
        end
    end

    // A and C share one polarity bit, B and D the other
    assign pol_pin = {pol_act_ff[0], pol_act_ff[1], pol_act_ff[0], pol_act_ff[1]};

    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_pin
            always_ff @(posedge clk_sys)
            begin
                if (srst || clear_all)
                begin
                    out_ff[g] <= 1'b0;
                    own_ff[g] <= 1'b0;
                end
                else
                begin
                    out_ff[g] <= nxt_act[g] ^ pol_pin[g];
                    own_ff[g] <= nxt_own[g];
                end
            end
        end
    endgenerate

    assign bridge_out_a = out_ff[0];
    assign bridge_out_b = out_ff[1];
    assign bridge_out_c = out_ff[2];
    assign bridge_out_d = out_ff[3];
    assign bridge_own_a = own_ff[0];
    assign bridge_own_b = own_ff[1];
    assign bridge_own_c = own_ff[2];
    assign bridge_own_d = own_ff[3];

    // Read data one cycle after the strobe, else zero
    always_ff @(posedge clk_sys)
    begin
        if (srst || !reg_rd)
            rdata_ff <= 8'h00;
        else
        begin
            case (reg_addr)
                `EBPWM_OFF_CONTROL: rdata_ff <= eccp_control_ff;
                `EBPWM_OFF_DUTY_HIGH: rdata_ff <= duty_high_byte_ff;
                `EBPWM_OFF_DUTY_SHADOW: rdata_ff <= duty_shadow_byte_ff;
                `EBPWM_OFF_PERIOD: rdata_ff <= period_register_ff;
                `EBPWM_OFF_DEAD_BAND: rdata_ff <= {1'b0, dead_band_control_ff};
                `EBPWM_OFF_TIMER_CTRL: rdata_ff <= {1'b0, timer_ctrl_ff};
                `EBPWM_OFF_TIMER: rdata_ff <= period_timer;
                `EBPWM_OFF_STATUS: rdata_ff <= {4'h0, early_ff, dir_ff,
                                                running, state_ff == EBPWM_ARMED};
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_ff;

endmodule

//--- bench/ebpwm_checker.sv
// Checker on the bridge PWM top ports.
// Assumes settings change only by register writes.
`timescale 1ns/1ns
`include "ebpwm_map.svh"

module ebpwm_checker
    import ebpwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Bridge outputs and ownership
    input wire logic bridge_out_a,
    input wire logic bridge_out_b,
    input wire logic bridge_out_c,
    input wire logic bridge_out_d,
    input wire logic bridge_own_a,
    input wire logic bridge_own_b,
    input wire logic bridge_own_c,
    input wire logic bridge_own_d
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [7:0] ctl_ff, duty_ff, per_ff, rb;
    logic [6:0] dead_ff, tctl_ff;
    logic [15:0] quiet_ff, gap_ff, hi_ff, pre, per_clks, act_clks;
    logic [9:0] duty;
    logic a_prev_ff, rise, fall, pwm, settled, single, duty_ok;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ctl_ff <= `EBPWM_RST_CONTROL;
            duty_ff <= `EBPWM_RST_BYTE;
            per_ff <= `EBPWM_RST_PERIOD;
            dead_ff <= `EBPWM_RST_DEAD_BAND;
            tctl_ff <= `EBPWM_RST_TCTL;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `EBPWM_OFF_CONTROL: ctl_ff <= reg_wdata;
                `EBPWM_OFF_DUTY_HIGH: duty_ff <= reg_wdata;
                `EBPWM_OFF_PERIOD: per_ff <= reg_wdata;
                `EBPWM_OFF_DEAD_BAND: dead_ff <= reg_wdata[6:0];
                `EBPWM_OFF_TIMER_CTRL: tctl_ff <= reg_wdata[6:0];
                default: ;
            endcase
        end
    end

    // Gap and high counters wrap, quiet counter saturates; trusted only once settled
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            a_prev_ff <= 1'b0;
            quiet_ff <= 16'h0000;
            gap_ff <= 16'h0000;
            hi_ff <= 16'h0000;
        end
        else
        begin
            a_prev_ff <= bridge_out_a;
            quiet_ff <= reg_wr ? 16'h0000 : quiet_ff + {15'h0000, quiet_ff != 16'hFFFF};
            gap_ff <= rise ? 16'h0001 : gap_ff + 16'h0001;
            hi_ff <= bridge_out_a ? hi_ff + 16'h0001 : 16'h0000;
        end
    end

    always_comb
    begin
        pre = tctl_ff[1] ? 16'h0010 : (tctl_ff[0] ? 16'h0004 : 16'h0001);
        per_clks = ({8'h00, per_ff} + 16'h0001) * 16'h0004 * pre;
        duty = {duty_ff, ctl_ff[5:4]};
        act_clks = {6'h00, duty} * pre;
        duty_ok = duty != 10'h000 && duty <= {per_ff, 2'h3};
        rise = bridge_out_a && !a_prev_ff;
        fall = !bridge_out_a && a_prev_ff;
        pwm = ctl_ff[3:2] == 2'h3;
        settled = tctl_ff[2] && quiet_ff > per_clks * 16'h0002 + 16'h0010;
        single = settled && pwm && ctl_ff[7:6] == 2'h0 && !ctl_ff[1];
        rb = reg_addr == `EBPWM_OFF_DUTY_HIGH ? duty_ff :
            {1'b0, reg_addr == `EBPWM_OFF_DEAD_BAND ? dead_ff : tctl_ff};
    end

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");

    property p_readback;
        reg_rd && reg_addr inside {`EBPWM_OFF_DUTY_HIGH, `EBPWM_OFF_DEAD_BAND,
            `EBPWM_OFF_TIMER_CTRL} |=> reg_rdata == $past(rb);
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");

    property p_own;
        settled |-> bridge_own_a == pwm && bridge_own_b == (pwm && ctl_ff[7:6] != 2'h0)
            && bridge_own_c == (pwm && ctl_ff[6]) && bridge_own_d == bridge_own_c;
    endproperty
    a_own: assert property (p_own) else $error("ownership wrong");

    property p_clear;
        reg_wr && reg_addr == `EBPWM_OFF_CONTROL && reg_wdata == 8'h00 |-> ##2
            {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} == 4'h0
            && {bridge_own_a, bridge_own_b, bridge_own_c, bridge_own_d} == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_period;
        single && duty_ok && rise |-> gap_ff == per_clks;
    endproperty
    a_period: assert property (p_period) else $error("period wrong");

    property p_width;
        single && duty_ok && fall |-> hi_ff == act_clks;
    endproperty
    a_width: assert property (p_width) else $error("width wrong");

    property p_half;
        settled && bridge_own_b && !bridge_own_c && ctl_ff[1:0] == 2'h0
            |-> !(bridge_out_a && bridge_out_b);
    endproperty
    a_half: assert property (p_half) else $error("leg overlap");

    property p_bridge;
        settled && bridge_own_c && ctl_ff[1:0] == 2'h0 |-> (ctl_ff[7] ?
            (bridge_out_c && !bridge_out_a && !bridge_out_d) :
            (bridge_out_a && !bridge_out_b && !bridge_out_c));
    endproperty
    a_bridge: assert property (p_bridge) else $error("steering wrong");

    c_single: cover property (single && duty_ok && fall);
    c_half: cover property (settled && bridge_own_b && !bridge_own_c);
    c_full: cover property (settled && bridge_own_c && ctl_ff[7]);
    c_clear: cover property (reg_wr && reg_addr == `EBPWM_OFF_CONTROL && reg_wdata == 8'h00);
endmodule

bind ebpwm_top ebpwm_checker i_ebpwm_checker (.*);

//--- bench/ebpwm_switches.sv
// Model of the power switch drivers on the four bridge pins.
// Assumes a released pin is pulled down; index 0 is output A.
`timescale 1ns/1ns

module ebpwm_switches
    import ebpwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Block outputs and ownership
    input wire logic [3:0] drive,
    input wire logic [3:0] own,
    // Pin levels and rising-edge counts
    output logic [3:0] pin,
    output logic [3:0][15:0] rises
);
    logic [3:0] prev_ff;

    // Pins are outputs only while owned
    assign pin = own & drive;

    always_ff @(posedge clk_sys)
    begin
        prev_ff <= pin;
        for (int i = 0; i < 4; i++)
        begin
            if (srst)
                rises[i] <= 16'h0000;
            else if (pin[i] && !prev_ff[i])
                rises[i] <= rises[i] + 16'h0001;
        end
    end
endmodule

//--- bench/enhanced_bridge_pwm_bench.sv
// Self-checking bench for the bridge PWM: registers, timing and steering.
// Assumes the bound checker and the switch model on the pins.
`timescale 1ns/1ns

module enhanced_bridge_pwm_bench;
    logic clk_sys, srst, reg_wr, reg_rd;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [3:0] outs, owns, pin, z;
    logic [3:0][15:0] rises;
    int error_cnt, checked;
    logic [7:0] rst_v [8] = '{3: 8'hFF, default: 8'h00};
    // Single-output cases: timer ctrl, control, duty, high and period clocks
    logic [7:0] tc [4] = '{8'h7C, 8'h05, 8'h06, 8'h04};
    logic [7:0] cc [4] = '{8'h0C, 8'h2C, 8'h1C, 8'h0E};
    logic [7:0] dh [4] = '{8'h01, 8'h01, 8'h02, 8'h02};
    int eh [4] = '{4, 24, 144, 8};
    int ep [4] = '{16, 64, 256, 16};
    logic [7:0] dv [3] = '{8'h01, 8'h04, 8'h00};

    ebpwm_top i_ebpwm_top (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bridge_out_a(outs[0]), .bridge_out_b(outs[1]), .bridge_out_c(outs[2]),
        .bridge_out_d(outs[3]), .bridge_own_a(owns[0]), .bridge_own_b(owns[1]),
        .bridge_own_c(owns[2]), .bridge_own_d(owns[3]));
    ebpwm_switches i_ebpwm_switches (.clk_sys(clk_sys), .srst(srst), .drive(outs),
        .own(owns), .pin(pin), .rises(rises));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("register %0d", a), {8'h00, exp}, {8'h00, reg_rdata});
    endtask

    task automatic wait_lvl(input logic inv, input logic lvl, output int cnt);
        cnt = 0;
        while ((pin[0] ^ inv) !== lvl && cnt < 5000)
        begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
        if (cnt >= 5000)
            chk("edge wait", 16'h0000, 16'h0001);
    endtask

    task automatic measure(input logic inv, input int exp_hi, input int exp_per);
        int n, hi, lo;
        @(posedge clk_sys);
        #1;
        wait_lvl(inv, 1'b0, n);
        wait_lvl(inv, 1'b1, n);
        wait_lvl(inv, 1'b0, hi);
        wait_lvl(inv, 1'b1, lo);
        chk("active", 16'(exp_hi), 16'(hi));
        chk("period", 16'(exp_per), 16'(hi + lo));
    endtask

    // Flag pins that rose in a 128-cycle window
    task automatic win(input int settle);
        logic [3:0][15:0] s;
        repeat (settle) @(posedge clk_sys);
        s = rises;
        repeat (128) @(posedge clk_sys);
        for (int i = 0; i < 4; i++)
            z[i] = rises[i] != s[i];
        #1;
    endtask

    // Run is near 3600 cycles; wide margin
    initial
    begin
        repeat (50000) @(posedge clk_sys);
        error_cnt++;
        close_out();
    end

    initial
    begin
        error_cnt = 0;
        checked = 0;
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        for (int a = 0; a < 8; a++)
            rd(3'(a), rst_v[a]);
        wr(3'h6, 8'hAA);
        wr(3'h7, 8'hFF);
        rd(3'h6, 8'h00);
        rd(3'h7, 8'h00);
        wr(3'h4, 8'hFF);
        rd(3'h4, 8'h7F);
        wr(3'h5, 8'hFF);
        rd(3'h5, 8'h7F);
        for (int k = 0; k < 4; k++)
        begin
            wr(3'h0, 8'h00);
            wr(3'h5, tc[k]);
            wr(3'h3, 8'h03);
            wr(3'h1, dh[k]);
            wr(3'h0, cc[k]);
            repeat (4 * ep[k]) @(posedge clk_sys);
            measure(cc[k][1], eh[k], ep[k]);
            wr(3'h2, 8'h55);
            rd(3'h2, dh[k]);
        end
        wr(3'h0, 8'h00);
        wr(3'h5, 8'h04);
        wr(3'h0, 8'h0C);
        for (int k = 0; k < 3; k++)
        begin
            wr(3'h1, dv[k]);
            win(64);
            chk("A toggles", {15'h0000, k == 0}, {15'h0000, z[0]});
        end
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h01);
        wr(3'h1, 8'h02);
        wr(3'h0, 8'h8C);
        win(64);
        chk("half bridge", 16'h0033, {8'h00, owns, z});
        wr(3'h4, 8'h7F);
        win(128);
        chk("dead band", 16'h0000, {15'h0000, z[0]});
        wr(3'h0, 8'h4C);
        win(64);
        chk("forward", 16'hF801, {owns, z, 6'h00, pin[2], pin[0]});
        wr(3'h0, 8'hCC);
        win(64);
        chk("reverse", 16'hF202, {owns, z, 6'h00, pin[2], pin[0]});
        wr(3'h0, 8'h00);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("cleared", 16'h0000, {8'h00, owns, outs});
        close_out();
    end
endmodule
